// ===== src/synth_cfg_pkg.sv
/*
  constants for the synthesizer serial configuration latches: word layout,
  field positions, codes and timing counts.
  assumes a single 125 MHz clock domain and that the serial pins are already
  synchronous to it.
*/
`default_nettype none
package synth_cfg_pkg;
  localparam int WORD_BITS = 24;
  localparam logic [1:0] SEL_FUNCTION  = 2'h0;
  localparam logic [1:0] SEL_REFERENCE = 2'h1;
  localparam logic [1:0] SEL_FEEDBACK  = 2'h2;
  localparam logic [1:0] SEL_TEST      = 2'h3;
  localparam logic [23:0] WORD_RESET   = 24'h00_0000;
  // function word
  localparam int FN_PRESC_LSB   = 22;
  localparam int FN_PD_SYNC     = 21;
  localparam int FN_PD_EN       = 20;
  localparam int FN_CUR_B_LSB   = 17;
  localparam int FN_CUR_A_LSB   = 14;
  localparam int FN_LEVEL_LSB   = 12;
  localparam int FN_MUTE        = 11;
  localparam int FN_GAIN        = 10;
  localparam int FN_PUMP_TRI    = 9;
  localparam int FN_POLARITY    = 8;
  localparam int FN_OBS_LSB     = 5;
  localparam int FN_CNT_RESET   = 4;
  localparam int FN_CORE_LSB    = 2;
  // reference word
  localparam int RF_BANDDIV_LSB = 20;
  localparam int RF_TEST_EN     = 19;
  localparam int RF_LOCK_PREC   = 18;
  localparam int RF_ABP_LSB     = 16;
  localparam int RF_RATIO_LSB   = 2;
  localparam int RF_RATIO_BITS  = 14;
  // feedback word
  localparam int FB_HALF_SEL    = 23;
  localparam int FB_HALVING     = 22;
  localparam int FB_GAIN        = 21;
  localparam int FB_MAIN_LSB    = 8;
  localparam int FB_MAIN_BITS   = 13;
  localparam int FB_SWAL_LSB    = 2;
  localparam int FB_SWAL_BITS   = 5;
  // observe pin codes
  localparam logic [2:0] OBS_HIZ   = 3'h0;
  localparam logic [2:0] OBS_LOCK  = 3'h1;
  localparam logic [2:0] OBS_FBDIV = 3'h2;
  localparam logic [2:0] OBS_HIGH  = 3'h3;
  localparam logic [2:0] OBS_RFDIV = 3'h4;
  localparam logic [2:0] OBS_ODLK  = 3'h5;
  localparam logic [2:0] OBS_SDO   = 3'h6;
  localparam logic [2:0] OBS_LOW   = 3'h7;
  // timing
  localparam int SYNC_PD_EDGES    = 2;
  localparam int LOCK_CYC_FINE    = 5;
  localparam int LOCK_CYC_COARSE  = 3;
  localparam int BAND_SEL_CYCLES  = 5;
  localparam int BAND_CLK_MAX_KHZ = 250;
  localparam int CLK_MHZ          = 125;
endpackage : synth_cfg_pkg
`default_nettype wire

// ===== src/cfg_bus_if.sv
/*
  carrier between the shifter and the latch bank: one strobed 24-bit word.
  assumes a single clock.
*/
`default_nettype none
interface cfg_bus_if;
  logic [23:0] word;
  logic        load;
  logic        sdo;
  modport source (output word, output load, output sdo);
  modport sink   (input word, input load, input sdo);
endinterface : cfg_bus_if
`default_nettype wire

// ===== src/serial_shifter.sv
/*
  24-bit serial input shifter: samples data on rising serial clock, reports
  the held word as a one-cycle load pulse on rising latch strobe.
  assumes sclk, sdata and latch_strobe already synchronous to mclk.
*/
`default_nettype none
module serial_shifter
  import synth_cfg_pkg::*;
(
  input  wire logic  mclk,
  input  wire logic  rst_b,
  input  wire logic  clkEn,
  input  wire logic  sclk,
  input  wire logic  sdata,
  input  wire logic  latchStrobe,
  cfg_bus_if.source  bus
);
  logic [23:0] shift_q, shift_d;
  logic        sclkOld_q, sclkOld_d;
  logic        leOld_q, leOld_d;
  logic        load_q, load_d;

  always_comb
  begin
    shift_d   = shift_q;
    sclkOld_d = sclk;
    leOld_d   = latchStrobe;
    load_d    = latchStrobe & ~leOld_q;
    if (sclk && !sclkOld_q)
    begin
      shift_d = {shift_q[22:0], sdata};
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      shift_q   <= WORD_RESET;
      sclkOld_q <= 1'b0;
      leOld_q   <= 1'b0;
      load_q    <= 1'b0;
    end
    else if (clkEn)
    begin
      shift_q   <= shift_d;
      sclkOld_q <= sclkOld_d;
      leOld_q   <= leOld_d;
      load_q    <= load_d;
    end
  end

  assign bus.word = shift_q;
  assign bus.load = load_q;
  assign bus.sdo  = shift_q[23];
endmodule : serial_shifter
`default_nettype wire

// ===== src/synth_serial_config_latches.sv
/*
  synthesizer programming logic: three configuration latches loaded over the
  3-wire port, power-down sequencing, band-select timing, lock counting,
  pump control and the observe pin multiplexer.
  assumes serial pins synchronous to mclk; refDivOut, fbDivOut and phaseOk are
  single-cycle-wide or level signals from the analog/counter side in mclk domain.
*/
`default_nettype none
module synth_serial_config_latches
  import synth_cfg_pkg::*;
#(
  parameter int BAND_CYCLES = BAND_SEL_CYCLES
)
(
  input  wire logic        mclk,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic        latchStrobe,
  input  wire logic        refDivOut,
  input  wire logic        fbDivOut,
  input  wire logic        phaseOk,
  output logic [1:0]       prescalerMode,
  output logic [6:0]       feedbackModulus,
  output logic [12:0]      mainCount,
  output logic [4:0]       swallowCount,
  output logic [13:0]      refRatio,
  output logic [2:0]       pumpCurrentCode,
  output logic             pumpTristate,
  output logic             detectorPolarity,
  output logic [1:0]       antibacklashCode,
  output logic [1:0]       outLevel,
  output logic [1:0]       coreCurrent,
  output logic             rfOutEnable,
  output logic             outputHalving,
  output logic             halvedFeedback,
  output logic             countersReset,
  output logic             poweredDown,
  output logic             refBufferEnable,
  output logic             bandSelectActive,
  output logic             bandClk,
  output logic             digitalLock,
  output logic             testLatchEnable,
  output logic             observeOut,
  output logic             observeOe
);
  cfg_bus_if bus ();

  serial_shifter shifter (
    .mclk        (mclk),
    .rst_b       (rst_b),
    .clkEn       (clkEn),
    .sclk        (sclk),
    .sdata       (sdata),
    .latchStrobe (latchStrobe),
    .bus         (bus)
  );

  function automatic logic [6:0] modulus_of(input logic [1:0] code);
    unique case (code)
      2'h0:    modulus_of = 7'h08;
      2'h1:    modulus_of = 7'h10;
      default: modulus_of = 7'h20;
    endcase
  endfunction : modulus_of

  ////////////////////////////////////////////////////////////////////////////
  // latches
  logic [23:0] fnWord_q, fnWord_d;
  logic [23:0] rfWord_q, rfWord_d;
  logic [23:0] fbWord_q, fbWord_d;
  logic        gain_q, gain_d;
  logic [2:0]  written_q, written_d;
  logic        fbWrite;
  logic [1:0]  sel;

  assign sel     = bus.word[1:0];
  assign fbWrite = bus.load && (sel == SEL_FEEDBACK);

  always_comb
  begin
    fnWord_d  = fnWord_q;
    rfWord_d  = rfWord_q;
    fbWord_d  = fbWord_q;
    gain_d    = gain_q;
    written_d = written_q;
    if (bus.load)
    begin
      unique case (sel)
        SEL_FUNCTION:
        begin
          fnWord_d     = bus.word;
          gain_d       = bus.word[FN_GAIN];
          written_d[0] = 1'b1;
        end
        SEL_REFERENCE:
        begin
          rfWord_d     = bus.word;
          written_d[1] = 1'b1;
        end
        SEL_FEEDBACK:
        begin
          fbWord_d     = bus.word;
          gain_d       = bus.word[FB_GAIN];
          written_d[2] = 1'b1;
        end
        SEL_TEST:
        begin
          // test word contents are not modelled here
        end
      endcase
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      fnWord_q  <= WORD_RESET;
      rfWord_q  <= WORD_RESET;
      fbWord_q  <= WORD_RESET;
      gain_q    <= 1'b0;
      written_q <= 3'h0;
    end
    else if (clkEn)
    begin
      fnWord_q  <= fnWord_d;
      rfWord_q  <= rfWord_d;
      fbWord_q  <= fbWord_d;
      gain_q    <= gain_d;
      written_q <= written_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-down sequencing
  typedef enum logic [1:0] {PD_RUN, PD_WAIT, PD_DOWN} pd_state_type;
  pd_state_type pd_q, pd_d;
  logic [1:0]   pdEdges_q, pdEdges_d;
  logic         refOld_q;
  logic         refRise;
  logic         initDone;
  logic         pdEn, pdSync;

  assign refRise  = refDivOut & ~refOld_q;
  assign initDone = &written_q;
  assign pdEn     = fnWord_q[FN_PD_EN];
  assign pdSync   = fnWord_q[FN_PD_SYNC];

  always_comb
  begin
    pd_d      = pd_q;
    pdEdges_d = pdEdges_q;
    unique case (pd_q)
      PD_RUN:
      begin
        if (pdEn && !pdSync)
          pd_d = PD_DOWN;
        else if (pdEn && pdSync)
        begin
          pd_d      = PD_WAIT;
          pdEdges_d = 2'h0;
        end
      end
      PD_WAIT:
      begin
        if (!pdEn)
          pd_d = PD_RUN;
        else if (refRise)
        begin
          pdEdges_d = pdEdges_q + 2'h1;
          if (pdEdges_q == 2'(SYNC_PD_EDGES - 1))
            pd_d = PD_DOWN;
        end
      end
      PD_DOWN:
      begin
        if (!pdEn)
          pd_d = PD_RUN;
      end
    endcase
    // a fresh function word restarts the synchronous wait from its strobe
    if (bus.load && sel == SEL_FUNCTION && bus.word[FN_PD_EN] && bus.word[FN_PD_SYNC] && pd_q != PD_DOWN)
    begin
      pd_d      = PD_WAIT;
      pdEdges_d = 2'h0;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      pd_q      <= PD_RUN;
      pdEdges_q <= 2'h0;
      refOld_q  <= 1'b0;
    end
    else if (clkEn)
    begin
      pd_q      <= pd_d;
      pdEdges_q <= pdEdges_d;
      refOld_q  <= refDivOut;
    end
  end

  logic down;
  assign down = (pd_q == PD_DOWN) || !initDone;

  ////////////////////////////////////////////////////////////////////////////
  // band-select clock, band-select window and lock detection
  logic [2:0] bandDiv_q, bandDiv_d;
  logic       bandTick;
  logic [3:0] band_q, band_d;
  logic       bandClk_d;
  logic [2:0] lockCnt_q, lockCnt_d;
  logic       lock_d;
  logic [2:0] lockNeed;

  assign lockNeed = rfWord_q[RF_LOCK_PREC] ? 3'(LOCK_CYC_FINE) : 3'(LOCK_CYC_COARSE);

  always_comb
  begin
    bandDiv_d = bandDiv_q;
    bandTick  = 1'b0;
    if (refRise)
    begin
      bandDiv_d = bandDiv_q + 3'h1;
      unique case (rfWord_q[RF_BANDDIV_LSB +: 2])
        2'h0: bandTick = 1'b1;
        2'h1: bandTick = bandDiv_q[0];
        2'h2: bandTick = &bandDiv_q[1:0];
        2'h3: bandTick = &bandDiv_q;
      endcase
    end
    // each counter bit is the reference output divided by twice its weight
    unique case (rfWord_q[RF_BANDDIV_LSB +: 2])
      2'h0: bandClk_d = refDivOut;
      2'h1: bandClk_d = bandDiv_d[0];
      2'h2: bandClk_d = bandDiv_d[1];
      2'h3: bandClk_d = bandDiv_d[2];
    endcase
    band_d = band_q;
    if (down)
      band_d = 4'(BAND_CYCLES);
    else if (fbWrite)
      band_d = 4'(BAND_CYCLES);
    else if (band_q != 4'h0 && bandTick)
      band_d = band_q - 4'h1;
    lockCnt_d = lockCnt_q;
    lock_d    = digitalLock;
    if (down || band_q != 4'h0)
    begin
      lockCnt_d = 3'h0;
      lock_d    = 1'b0;
    end
    else if (refRise)
    begin
      if (!phaseOk)
      begin
        lockCnt_d = 3'h0;
        lock_d    = 1'b0;
      end
      else if (lockCnt_q + 3'h1 >= lockNeed)
      begin
        lockCnt_d = lockNeed;
        lock_d    = 1'b1;
      end
      else
        lockCnt_d = lockCnt_q + 3'h1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      bandDiv_q   <= 3'h0;
      band_q      <= 4'h0;
      lockCnt_q   <= 3'h0;
      digitalLock <= 1'b0;
      bandClk     <= 1'b0;
    end
    else if (clkEn)
    begin
      bandDiv_q   <= bandDiv_d;
      band_q      <= band_d;
      lockCnt_q   <= lockCnt_d;
      digitalLock <= lock_d;
      bandClk     <= bandClk_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered outputs
  logic [2:0] obsSel;
  logic       obs_d, obsOe_d;
  assign obsSel = fnWord_q[FN_OBS_LSB +: 3];

  always_comb
  begin
    obs_d   = 1'b0;
    obsOe_d = 1'b1;
    unique case (obsSel)
      OBS_HIZ:   obsOe_d = 1'b0;
      OBS_LOCK:  obs_d   = digitalLock;
      OBS_FBDIV: obs_d   = fbDivOut;
      OBS_HIGH:  obs_d   = 1'b1;
      OBS_RFDIV: obs_d   = refDivOut;
      OBS_ODLK:  obsOe_d = ~digitalLock; // open drain: pull low only
      OBS_SDO:   obs_d   = bus.sdo;
      OBS_LOW:   obs_d   = 1'b0;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      prescalerMode    <= 2'h0;
      feedbackModulus  <= 7'h08;
      mainCount        <= 13'h0000;
      swallowCount     <= 5'h00;
      refRatio         <= 14'h0000;
      pumpCurrentCode  <= 3'h0;
      pumpTristate     <= 1'b1;
      detectorPolarity <= 1'b0;
      antibacklashCode <= 2'h0;
      outLevel         <= 2'h0;
      coreCurrent      <= 2'h0;
      rfOutEnable      <= 1'b0;
      outputHalving    <= 1'b0;
      halvedFeedback   <= 1'b0;
      countersReset    <= 1'b1;
      poweredDown      <= 1'b1;
      refBufferEnable  <= 1'b0;
      bandSelectActive <= 1'b0;
      testLatchEnable  <= 1'b0;
      observeOut       <= 1'b0;
      observeOe        <= 1'b0;
    end
    else if (clkEn)
    begin
      prescalerMode    <= fnWord_q[FN_PRESC_LSB +: 2];
      feedbackModulus  <= modulus_of(fnWord_q[FN_PRESC_LSB +: 2]);
      mainCount        <= fbWord_q[FB_MAIN_LSB +: FB_MAIN_BITS];
      swallowCount     <= fbWord_q[FB_SWAL_LSB +: FB_SWAL_BITS];
      refRatio         <= rfWord_q[RF_RATIO_LSB +: RF_RATIO_BITS];
      pumpCurrentCode  <= gain_q ? fnWord_q[FN_CUR_B_LSB +: 3] : fnWord_q[FN_CUR_A_LSB +: 3];
      // init and power-down force three-state ahead of the user bit
      pumpTristate     <= down | fnWord_q[FN_PUMP_TRI];
      detectorPolarity <= fnWord_q[FN_POLARITY];
      antibacklashCode <= rfWord_q[RF_ABP_LSB +: 2];
      outLevel         <= fnWord_q[FN_LEVEL_LSB +: 2];
      coreCurrent      <= fnWord_q[FN_CORE_LSB +: 2];
      rfOutEnable      <= !down && (!fnWord_q[FN_MUTE] || digitalLock);
      outputHalving    <= fbWord_q[FB_HALVING];
      halvedFeedback   <= fbWord_q[FB_HALF_SEL];
      // counters also held in their load state while powered down
      countersReset    <= (initDone && fnWord_q[FN_CNT_RESET]) || down;
      poweredDown      <= down;
      refBufferEnable  <= !down;
      bandSelectActive <= !down && band_q != 4'h0;
      testLatchEnable  <= rfWord_q[RF_TEST_EN];
      observeOut       <= obs_d;
      observeOe        <= obsOe_d;
    end
  end
endmodule : synth_serial_config_latches
`default_nettype wire

// ===== sim/cfg_latches_sva.sv
/*
  port assertions for the configuration latch block.
  assumes one clock domain and a synchronous active-low reset.
*/
`default_nettype none
module cfg_latches_sva
  import synth_cfg_pkg::*;
(
  input wire logic        mclk,
  input wire logic        rst_b,
  input wire logic        latchStrobe,
  input wire logic [1:0]  prescalerMode,
  input wire logic [6:0]  feedbackModulus,
  input wire logic [12:0] mainCount,
  input wire logic [13:0] refRatio,
  input wire logic        pumpTristate,
  input wire logic        countersReset,
  input wire logic        poweredDown,
  input wire logic        refBufferEnable,
  input wire logic        rfOutEnable,
  input wire logic        bandSelectActive,
  input wire logic        digitalLock
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////
  property p_tri; poweredDown |-> pumpTristate; endproperty
  a_tri: assert property (p_tri) else $error("pump driving while down");
  property p_down; poweredDown |-> countersReset && !refBufferEnable; endproperty
  a_down: assert property (p_down) else $error("counters or buffer live while down");
  property p_mod; feedbackModulus == (prescalerMode == 2'h0 ? 7'h08 : prescalerMode == 2'h1 ? 7'h10 : 7'h20); endproperty
  a_mod: assert property (p_mod) else $error("modulus does not match prescaler code");
  property p_lockoff; poweredDown [*2] |-> !digitalLock; endproperty
  a_lockoff: assert property (p_lockoff) else $error("lock held while down");
  property p_band; poweredDown |-> !bandSelectActive; endproperty
  a_band: assert property (p_band) else $error("band window while down");
  // five quiet samples cover the three-edge load latency with margin
  property p_hold; !latchStrobe [*5] |-> $stable(mainCount) && $stable(refRatio); endproperty
  a_hold: assert property (p_hold) else $error("latch moved without strobe");
  property p_mute; rfOutEnable |-> !poweredDown; endproperty
  a_mute: assert property (p_mute) else $error("output on while down");
  property p_lockrise; $rose(digitalLock) |-> !poweredDown && !bandSelectActive; endproperty
  a_lockrise: assert property (p_lockrise) else $error("lock set during band select");
endmodule : cfg_latches_sva
bind synth_serial_config_latches cfg_latches_sva cfg_latches_sva_i (.mclk, .rst_b, .latchStrobe, .prescalerMode,
  .feedbackModulus, .mainCount, .refRatio, .pumpTristate, .countersReset, .poweredDown, .refBufferEnable,
  .rfOutEnable, .bandSelectActive, .digitalLock);
`default_nettype wire

// ===== sim/host_serial_model.sv
/*
  host controller model for the three-wire programming port.
  assumes callers enter send one step after a rising mclk edge.
*/
`default_nettype none
module host_serial_model
(
  input  wire logic mclk,
  output var logic  sclk,
  output var logic  sdata,
  output var logic  latchStrobe
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk = 1'b0;
    sdata = 1'b0;
    latchStrobe = 1'b0;
  end
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick
  // each level held two cycles: the port samples sclk every cycle, so one cycle per level would do
  task automatic send(input logic [23:0] v);
    for (int i = 23; i >= 0; i--)
    begin
      sclk = 1'b0;
      sdata = v[i];
      tick(2);
      sclk = 1'b1;
      tick(2);
    end
    sclk = 1'b0;
    sdata = ~v[0]; // line released: show the inverse, not the last bit
    latchStrobe = 1'b1;
    tick(2);
    latchStrobe = 1'b0;
    tick(1);
  endtask : send
endmodule : host_serial_model
`default_nettype wire

// ===== sim/synth_serial_config_latches_tb.sv
/*
  self-checking bench for the configuration latch block.
  assumes the host model drives the serial pins; the reference output is made here.
*/
`default_nettype none
module synth_serial_config_latches_tb
  import synth_cfg_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_b, clkEn, refDivOut, fbDivOut, phaseOk;
  wire logic sclk, sdata, latchStrobe;
  logic [1:0] prescalerMode, antibacklashCode, outLevel, coreCurrent;
  logic [6:0] feedbackModulus;
  logic [12:0] mainCount;
  logic [4:0] swallowCount;
  logic [13:0] refRatio;
  logic [2:0] pumpCurrentCode, seen;
  logic pumpTristate, detectorPolarity, rfOutEnable, outputHalving, halvedFeedback, countersReset;
  logic poweredDown, refBufferEnable, bandSelectActive, bandClk, digitalLock, testLatchEnable;
  logic observeOut, observeOe, gain, pd;
  logic [23:0] fn, rf, fb, w;
  logic [3:0] refCnt;
  int errors, comparisons, n;
  time t;
  int seed = 32'hc838_465c;
  synth_serial_config_latches #(.BAND_CYCLES(2)) synth_serial_config_latches_i (.mclk, .rst_b, .clkEn,
    .sclk, .sdata, .latchStrobe, .refDivOut, .fbDivOut, .phaseOk, .prescalerMode, .feedbackModulus,
    .mainCount, .swallowCount, .refRatio, .pumpCurrentCode, .pumpTristate, .detectorPolarity,
    .antibacklashCode, .outLevel, .coreCurrent, .rfOutEnable, .outputHalving, .halvedFeedback,
    .countersReset, .poweredDown, .refBufferEnable, .bandSelectActive, .bandClk, .digitalLock,
    .testLatchEnable, .observeOut, .observeOe);
  host_serial_model host_serial_model_i (.mclk, .sclk, .sdata, .latchStrobe);
  ////////////////////////////////////////////////////////////////////////////
  always #4 mclk = ~mclk;
  always @(posedge mclk)
  begin
    #1;
    refCnt = refCnt + 4'h1;
    refDivOut = (refCnt < 4'h4);
  end
  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask : tick
  task automatic test_done();
    if (errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %0h expected %0h", $time, got, exp);
    end
  endtask : check
  // reference model: latest word per select, shared gain bit, init tracking
  task automatic put(input logic [23:0] v);
    host_serial_model_i.send(v);
    case (v[1:0])
      SEL_FUNCTION: {fn, gain, seen[0]} = {v, v[FN_GAIN], 1'b1};
      SEL_REFERENCE: {rf, seen[1]} = {v, 1'b1};
      SEL_FEEDBACK: {fb, gain, seen[2]} = {v, v[FB_GAIN], 1'b1};
      default: ;
    endcase
    pd = (seen != 3'h7) || (fn[FN_PD_EN] && !fn[FN_PD_SYNC]);
    tick(4);
  endtask : put
  task automatic chk_all();
    check(prescalerMode, fn[23:22]);
    check(feedbackModulus, fn[23:22] == 2'h0 ? 8 : fn[23:22] == 2'h1 ? 16 : 32);
    check(mainCount, fb[20:8]);
    check(swallowCount, fb[6:2]);
    check(refRatio, rf[15:2]);
    check(pumpCurrentCode, gain ? fn[19:17] : fn[16:14]);
    check(pumpTristate, pd | fn[FN_PUMP_TRI]);
    check(countersReset, pd | fn[FN_CNT_RESET]);
    check(refBufferEnable, !pd);
    check(poweredDown, pd);
    check(antibacklashCode, rf[17:16]);
    check(testLatchEnable, rf[RF_TEST_EN]);
    check({halvedFeedback, outputHalving}, fb[23:22]);
    check(rfOutEnable, !pd && !fn[FN_MUTE]);
    check({detectorPolarity, outLevel, coreCurrent}, {fn[8], fn[13:12], fn[3:2]});
  endtask : chk_all
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    mclk = 1'b0;
    rst_b = 1'b0;
    clkEn = 1'b1;
    refDivOut = 1'b0;
    fbDivOut = 1'b1;
    phaseOk = 1'b0;
    refCnt = 4'h0;
    {fn, rf, fb, gain, seen} = '0;
    pd = 1'b1;
    tick(3);
    rst_b = 1'b1;
    chk_all();
    for (int i = 0; i < 3; i++)
    begin
      w = $random(seed);
      w[1:0] = SEL_REFERENCE;
      if (w[15:2] == 14'h0000) w[15:2] = 14'h0001;
      put(w);
      chk_all();
      w = $random(seed);
      w[21:20] = 2'h0;
      w[8] = 1'b1;
      w[1:0] = SEL_FUNCTION;
      put(w);
      chk_all();
      w = $random(seed);
      w[1:0] = SEL_FEEDBACK;
      if (w[20:8] < 13'h0003) w[20:8] = 13'h0003;
      put(w);
      chk_all();
    end
    w = $random(seed);
    w[1:0] = SEL_TEST;
    put(w);
    chk_all();
    put(fb ^ 24'h20_0000);
    chk_all();
    check(bandSelectActive, 1'b1);
    w = fn;
    w[21:20] = 2'h1;
    put(w);
    chk_all();
    w[21:20] = 2'h0;
    put(w);
    chk_all();
    w[21:20] = 2'h3;
    put(w);
    check(poweredDown, 1'b0);
    tick(40);
    pd = 1'b1;
    chk_all();
    w[21:20] = 2'h0;
    put(w);
    chk_all();
    for (int c = 0; c < 8; c++)
    begin
      w[7:5] = c[2:0];
      put(w);
      check(observeOe, c != 0);
      if (c != 0 && c != 4 && c != 6)
        check(observeOut, c == 2 || c == 3);
    end
    for (int c = 0; c < 4; c++)
    begin
      put({2'h0, c[1:0], 4'h0, 14'h0004, SEL_REFERENCE});
      @(posedge bandClk);
      t = $time;
      @(posedge bandClk);
      n = int'(($time - t) / 8);
      check(n, 16 << c);
    end
    w[FN_MUTE] = 1'b1;
    put(w);
    for (int p = 0; p < 2; p++)
    begin
      phaseOk = 1'b0;
      put({2'h0, 2'h0, 1'b0, p[0], 2'h0, 14'h0004, SEL_REFERENCE});
      tick(300);
      check(rfOutEnable, 1'b0);
      check(bandSelectActive, 1'b0);
      // start between reference pulses so the first counted rise is whole
      @(negedge refDivOut);
      tick(1);
      phaseOk = 1'b1;
      n = 0;
      repeat (8)
      begin
        @(posedge refDivOut);
        tick(3);
        n++;
        if (digitalLock === 1'b1) break;
      end
      check(n, p ? 5 : 3);
      check(rfOutEnable, 1'b1);
    end
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge mclk);
    errors++;
    test_done();
  end
endmodule : synth_serial_config_latches_tb
`default_nettype wire
